// ### verilog/erf_params.svh
// constants of the receive filter: field positions, sizes, hash and checksum figures
// assumes it is included by bare name from the filter package and modules
//
// Overview of operation
// - unicast: all six destination bytes equal local address
// - pattern: ones-complement checksum of window equals expected
// - window starts at offset from destination's first byte
// - one mask bit per window byte selects it
// - window past frame end fails pattern test
// - masked bytes skipped, later bytes re-pair
// - wake-up: local destination, six FF, sixteen address copies
// - hash: destination CRC indexes table, bit must be set
// - empty table never passes, full table always passes
// - multicast: group bit of first byte set
// - broadcast: destination bytes all ones
// - half duplex loops own frames into receive
// - diagnostic loopback frames go through all enabled tests like received frames
// - AND needs every enabled test; OR any
// - CRC check drops bad-FCS frames when enabled
// - all controls clear accepts every frame
`ifndef ERF_PARAMS_SVH
`define ERF_PARAMS_SVH

`define ERF_UNICAST_EN_BIT   7
`define ERF_COMBINE_SEL_BIT  6
`define ERF_CRC_CHECK_BIT    5
`define ERF_PATTERN_EN_BIT   4
`define ERF_WAKEUP_EN_BIT    3
`define ERF_HASH_EN_BIT      2
`define ERF_MCAST_EN_BIT     1
`define ERF_BCAST_EN_BIT     0

`define ERF_MAC_BYTES        6
`define ERF_WIN_BYTES        64
`define ERF_SYNC_BYTES       6
`define ERF_ADDR_REPS        16
`define ERF_DATA_START       14
`define ERF_SYNC_VALUE       8'hFF
`define ERF_CRC_INIT         32'hFFFFFFFF
`define ERF_CRC_POLY         32'hEDB88320
`define ERF_HASH_LSB         23
`define ERF_HASH_IDX_W       6

`endif

// ### verilog/erf_pkg.sv
// types shared by the receive filter modules
// assumes erf_params.svh is on the include path
`include "erf_params.svh"

package erf_pkg;

    typedef logic [7:0] erf_byte_t;

    typedef enum logic [1:0] {
        ERF_MG_SYNC = 2'b01,
        ERF_MG_ADDR = 2'b10
    } erf_mg_state_t;

endpackage : erf_pkg

// ### verilog/erf_csum_if.sv
// carrier between the filter and its checksum accumulator
// assumes both ends run on the same clock
`timescale 1ns/10ps

interface erf_csum_if;
    import erf_pkg::*;
    logic       clr;
    logic       add;
    erf_byte_t  data;
    logic [15:0] sum;

    modport acc  (input clr, input add, input data, output sum);
    modport user (output clr, output add, output data, input sum);
endinterface : erf_csum_if

// ### verilog/erf_csum.sv
// ones-complement checksum accumulator fed one included byte at a time
// assumes clr and add are same-clock strobes; clr with add starts a new sum with that byte
`timescale 1ns/10ps

module erf_csum (
    input  wire logic core_clk,
    input  wire logic rst,
    erf_csum_if.acc   bus
);
    import erf_pkg::*;

    logic [15:0] acc_ff;
    logic [15:0] nxt_acc;
    erf_byte_t   hi_ff;
    erf_byte_t   nxt_hi;
    logic        odd_ff;
    logic        nxt_odd;

    function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        oc_add = s[15:0] + {15'h0000, s[16]};
    endfunction : oc_add

    ////////////////////////////////////////////////////////////////////////////
    // only included bytes reach here, so pairing follows the included stream
    always_comb begin
        logic [15:0] b_acc;
        logic        b_odd;
        b_acc   = bus.clr ? 16'h0000 : acc_ff;
        b_odd   = bus.clr ? 1'b0 : odd_ff;
        nxt_acc = b_acc;
        nxt_hi  = hi_ff;
        nxt_odd = b_odd;
        if (bus.add) begin
            if (!b_odd) begin
                nxt_hi  = bus.data;
                nxt_odd = 1'b1;
            end else begin
                nxt_acc = oc_add(b_acc, {hi_ff, bus.data});
                nxt_odd = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc_ff <= 16'h0000;
            hi_ff  <= 8'h00;
            odd_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            hi_ff  <= nxt_hi;
            odd_ff <= nxt_odd;
        end
    end

    // a lone trailing byte is padded with a zero low byte
    assign bus.sum = ~(odd_ff ? oc_add(acc_ff, {hi_ff, 8'h00}) : acc_ff);

endmodule : erf_csum

// ### verilog/erf_filter.sv
// receive address and content filter: six tests, combine, CRC gate, keep/drop
// assumes byte streams from the MAC on core_clk, one byte per valid cycle,
// sof with the first destination byte and eof with the last CRC byte
`timescale 1ns/10ps

module erf_filter #(
    parameter int IDX_W = 16,
    parameter int OFS_W = 13
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                rx_valid,
    input  wire logic                rx_sof,
    input  wire logic                rx_eof,
    input  wire erf_pkg::erf_byte_t  rx_data,
    input  wire logic                rx_crc_ok,
    input  wire logic                tx_valid,
    input  wire logic                tx_sof,
    input  wire logic                tx_eof,
    input  wire erf_pkg::erf_byte_t  tx_data,
    input  wire logic                full_duplex_mode,
    input  wire logic                diagnostic_loopback_enable,
    input  wire logic                half_duplex_loopback_disable,
    input  wire logic [47:0]         local_mac_address,
    input  wire logic [15:0]         pattern_expected_checksum,
    input  wire logic [OFS_W-1:0]    pattern_window_offset,
    input  wire logic [63:0]         pattern_byte_mask,
    input  wire logic [63:0]         hash_table_bits,
    input  wire logic [7:0]          receive_filter_control,
    output logic                     frame_keep,
    output logic                     frame_drop,
    output logic [5:0]               filter_hits
);
    import erf_pkg::*;

    generate
        if (IDX_W < 11 || OFS_W > IDX_W || OFS_W < 1) begin : g_bad
            $error("erf_filter: IDX_W must be >= 11 and cover OFS_W");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // source select: looped transmit frames enter like network frames, except that their FCS counts as good
    logic      loop_on;
    logic      use_tx;
    logic      s_valid;
    logic      s_sof;
    logic      s_eof;
    erf_byte_t s_data;
    logic      s_crc_ok;

    always_comb begin
        loop_on  = full_duplex_mode ? diagnostic_loopback_enable
                                    : !half_duplex_loopback_disable;
        // full-duplex loopback ignores the wire; half duplex owns the medium while sending
        use_tx   = loop_on && (full_duplex_mode || tx_valid);
        s_valid  = use_tx ? tx_valid : rx_valid;
        s_sof    = use_tx ? tx_sof : rx_sof;
        s_eof    = use_tx ? tx_eof : rx_eof;
        s_data   = use_tx ? tx_data : rx_data;
        // own frames carry a freshly generated FCS
        s_crc_ok = use_tx ? 1'b1 : rx_crc_ok;
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-byte test state
    erf_csum_if csum ();

    erf_csum u_csum (
        .core_clk (core_clk),
        .rst      (rst),
        .bus      (csum)
    );

    logic [IDX_W-1:0] idx_ff,    nxt_idx;
    logic [IDX_W-1:0] len_ff,    nxt_len;
    logic             uc_ff,     nxt_uc;
    logic             bc_ff,     nxt_bc;
    logic             mc_ff,     nxt_mc;
    logic [31:0]      crc_ff,    nxt_crc;
    erf_mg_state_t    mg_st_ff,  nxt_mg_st;
    logic [4:0]       mg_cnt_ff, nxt_mg_cnt;
    logic [2:0]       mg_pos_ff, nxt_mg_pos;
    logic             mg_hit_ff, nxt_mg_hit;
    logic             done_ff,   nxt_done;
    logic             crcok_ff,  nxt_crcok;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input erf_byte_t d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = r[0] ^ d[i] ? ((r >> 1) ^ `ERF_CRC_POLY) : (r >> 1);
        end
        crc_byte = r;
    endfunction : crc_byte

    always_comb begin
        logic [IDX_W-1:0] p;
        logic [IDX_W:0]   rel;
        erf_byte_t        exp_b;
        p          = s_sof ? '0 : idx_ff;
        rel        = {1'b0, p} - {{(IDX_W - OFS_W + 1){1'b0}}, pattern_window_offset};
        exp_b      = local_mac_address[8 * (`ERF_MAC_BYTES - 1 - int'(mg_pos_ff)) +: 8];
        nxt_idx    = idx_ff;
        nxt_len    = len_ff;
        nxt_uc     = uc_ff;
        nxt_bc     = bc_ff;
        nxt_mc     = mc_ff;
        nxt_crc    = crc_ff;
        nxt_mg_st  = mg_st_ff;
        nxt_mg_cnt = mg_cnt_ff;
        nxt_mg_pos = mg_pos_ff;
        nxt_mg_hit = mg_hit_ff;
        nxt_done   = 1'b0;
        nxt_crcok  = crcok_ff;
        csum.clr   = s_valid && s_sof;
        csum.data  = s_data;
        // window byte k is included by mask bit k
        csum.add   = s_valid && !rel[IDX_W] && rel < (IDX_W + 1)'(`ERF_WIN_BYTES)
                     && pattern_byte_mask[rel[5:0]];
        if (s_valid) begin
            if (s_sof) begin
                nxt_uc     = 1'b1;
                nxt_bc     = 1'b1;
                nxt_crc    = `ERF_CRC_INIT;
                nxt_mg_st  = ERF_MG_SYNC;
                nxt_mg_cnt = 5'h00;
                nxt_mg_pos = 3'h0;
                nxt_mg_hit = 1'b0;
                nxt_mc     = s_data[0];
            end
            nxt_idx = p + 1'b1;
            if (p < IDX_W'(`ERF_MAC_BYTES)) begin
                if (s_data != local_mac_address[8 * (`ERF_MAC_BYTES - 1 - int'(p)) +: 8])
                    nxt_uc = 1'b0;
                if (s_data != 8'hFF)
                    nxt_bc = 1'b0;
                nxt_crc = crc_byte(s_sof ? `ERF_CRC_INIT : crc_ff, s_data);
            end else if (p >= IDX_W'(`ERF_DATA_START) && !mg_hit_ff) begin
                // wake-up search over the data field
                case (mg_st_ff)
                    ERF_MG_SYNC: begin
                        if (s_data == `ERF_SYNC_VALUE) begin
                            if (mg_cnt_ff == 5'(`ERF_SYNC_BYTES - 1)) begin
                                nxt_mg_st  = ERF_MG_ADDR;
                                nxt_mg_cnt = 5'h00;
                                nxt_mg_pos = 3'h0;
                            end else begin
                                nxt_mg_cnt = mg_cnt_ff + 5'h01;
                            end
                        end else begin
                            nxt_mg_cnt = 5'h00;
                        end
                    end
                    ERF_MG_ADDR: begin
                        if (s_data == exp_b) begin
                            if (mg_pos_ff == 3'(`ERF_MAC_BYTES - 1)) begin
                                nxt_mg_pos = 3'h0;
                                if (mg_cnt_ff == 5'(`ERF_ADDR_REPS - 1))
                                    nxt_mg_hit = 1'b1;
                                else
                                    nxt_mg_cnt = mg_cnt_ff + 5'h01;
                            end else begin
                                nxt_mg_pos = mg_pos_ff + 3'h1;
                            end
                        end else if (s_data == `ERF_SYNC_VALUE && mg_cnt_ff == 5'h00
                                     && mg_pos_ff == 3'h0) begin
                            // longer sync runs stay in place
                            nxt_mg_st = ERF_MG_ADDR;
                        end else begin
                            nxt_mg_st  = ERF_MG_SYNC;
                            nxt_mg_cnt = (s_data == `ERF_SYNC_VALUE) ? 5'h01 : 5'h00;
                            nxt_mg_pos = 3'h0;
                        end
                    end
                    default: begin
                        nxt_mg_st  = ERF_MG_SYNC;
                        nxt_mg_cnt = 5'h00;
                    end
                endcase
            end
            if (s_eof) begin
                nxt_len   = p + 1'b1;
                nxt_done  = 1'b1;
                nxt_crcok = s_crc_ok;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            idx_ff    <= '0;
            len_ff    <= '0;
            uc_ff     <= 1'b0;
            bc_ff     <= 1'b0;
            mc_ff     <= 1'b0;
            crc_ff    <= `ERF_CRC_INIT;
            mg_st_ff  <= ERF_MG_SYNC;
            mg_cnt_ff <= 5'h00;
            mg_pos_ff <= 3'h0;
            mg_hit_ff <= 1'b0;
            done_ff   <= 1'b0;
            crcok_ff  <= 1'b0;
        end else begin
            idx_ff    <= nxt_idx;
            len_ff    <= nxt_len;
            uc_ff     <= nxt_uc;
            bc_ff     <= nxt_bc;
            mc_ff     <= nxt_mc;
            crc_ff    <= nxt_crc;
            mg_st_ff  <= nxt_mg_st;
            mg_cnt_ff <= nxt_mg_cnt;
            mg_pos_ff <= nxt_mg_pos;
            mg_hit_ff <= nxt_mg_hit;
            done_ff   <= nxt_done;
            crcok_ff  <= nxt_crcok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decision, one cycle after the last byte so the checksum holds it
    logic       keep_ff, nxt_keep;
    logic       drop_ff, nxt_drop;
    logic [5:0] hits_ff, nxt_hits;

    always_comb begin
        logic [5:0]     hit;
        logic [5:0]     en;
        logic [IDX_W:0] need;
        logic           pass;
        pass = 1'b0;
        hit  = 6'h00;
        need = {{(IDX_W - OFS_W + 1){1'b0}}, pattern_window_offset}
               + (IDX_W + 1)'(`ERF_WIN_BYTES);
        hit[5] = uc_ff;
        hit[4] = ({1'b0, len_ff} >= need)
                 && (csum.sum == pattern_expected_checksum);
        hit[3] = uc_ff && mg_hit_ff;
        // one table bit per index, so empty/full tables decide alone
        hit[2] = hash_table_bits[crc_ff[`ERF_HASH_LSB +: `ERF_HASH_IDX_W]];
        hit[1] = mc_ff;
        hit[0] = bc_ff;
        en     = {receive_filter_control[`ERF_UNICAST_EN_BIT],
                  receive_filter_control[`ERF_PATTERN_EN_BIT:`ERF_BCAST_EN_BIT]};
        if (receive_filter_control[`ERF_COMBINE_SEL_BIT])
            pass = &(~en | hit);
        else
            pass = (en == 6'h00) || |(en & hit);
        if (receive_filter_control[`ERF_CRC_CHECK_BIT] && !crcok_ff)
            pass = 1'b0;
        nxt_keep = done_ff && pass;
        nxt_drop = done_ff && !pass;
        nxt_hits = done_ff ? hit : hits_ff;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            keep_ff <= 1'b0;
            drop_ff <= 1'b0;
            hits_ff <= 6'h00;
        end else begin
            keep_ff <= nxt_keep;
            drop_ff <= nxt_drop;
            hits_ff <= nxt_hits;
        end
    end

    assign frame_keep  = keep_ff;
    assign frame_drop  = drop_ff;
    assign filter_hits = hits_ff;

endmodule : erf_filter

// ### bench/erf_filter_monitor.sv
// checker of the filter's verdict timing and combining
// assumes it is bound to erf_filter and sees only its ports
`timescale 1ns/10ps

module erf_filter_monitor (
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic               rx_valid,
    input wire logic               rx_sof,
    input wire logic               rx_eof,
    input wire erf_pkg::erf_byte_t rx_data,
    input wire logic               rx_crc_ok,
    input wire logic               tx_valid,
    input wire logic               tx_sof,
    input wire logic               tx_eof,
    input wire erf_pkg::erf_byte_t tx_data,
    input wire logic               full_duplex_mode,
    input wire logic               diagnostic_loopback_enable,
    input wire logic               half_duplex_loopback_disable,
    input wire logic [7:0]         receive_filter_control,
    input wire logic               frame_keep,
    input wire logic               frame_drop,
    input wire logic [5:0]         filter_hits
);
    import erf_pkg::*;
    logic      sel_tx;
    logic      sel_eof;
    logic      sel_bad;
    logic      dec;
    logic [5:0] en;
    erf_byte_t first_ff;
    erf_byte_t dec_first_ff;
    assign sel_tx  = full_duplex_mode ? diagnostic_loopback_enable
                                      : (!half_duplex_loopback_disable && tx_valid);
    assign sel_eof = sel_tx ? (tx_valid && tx_eof) : (rx_valid && rx_eof);
    // looped frames count as good FCS
    assign sel_bad = sel_eof && !sel_tx && !rx_crc_ok;
    assign dec     = frame_keep || frame_drop;
    assign en      = {receive_filter_control[7], receive_filter_control[4:0]};
    always_ff @(posedge core_clk) begin
        if (sel_tx ? (tx_valid && tx_sof) : (rx_valid && rx_sof))
            first_ff <= sel_tx ? tx_data : rx_data;
        // copied at eof so a following sof cannot spoil it
        if (sel_eof)
            dec_first_ff <= first_ff;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_verdict_delay: assert property (sel_eof |-> ##2 dec)
        else $error("no verdict two cycles after frame end");
    a_verdict_cause: assert property (dec |-> $past(sel_eof, 2))
        else $error("verdict without a frame end");
    a_one_verdict: assert property (!(frame_keep && frame_drop))
        else $error("keep and drop together");
    a_pulse_short: assert property (dec |=> !dec)
        else $error("verdict longer than one cycle");
    a_hits_hold: assert property (!dec |-> $stable(filter_hits))
        else $error("hits changed without verdict");
    a_promisc_keep: assert property ($past(sel_eof, 2)
        && $past(receive_filter_control) == 8'h00 |-> frame_keep)
        else $error("frame dropped with all controls clear");
    a_crc_gate: assert property ($past(sel_bad, 2)
        && $past(receive_filter_control[5]) |-> frame_drop)
        else $error("bad FCS frame kept");
    a_and_every: assert property (frame_keep && $past(receive_filter_control[6])
        |-> ($past(en) & ~filter_hits) == 6'h00)
        else $error("AND keep with a failed test");
    a_or_any: assert property (frame_drop && !$past(receive_filter_control[6])
        && !($past(sel_bad, 2) && $past(receive_filter_control[5]))
        |-> $past(en) != 6'h00 && ($past(en) & filter_hits) == 6'h00)
        else $error("OR drop with a passed test");
    a_group_bit: assert property (dec |-> filter_hits[1] == dec_first_ff[0])
        else $error("multicast hit differs from group bit");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !frame_keep && !frame_drop && filter_hits == 6'h00)
        else $error("outputs active after reset");
endmodule : erf_filter_monitor

// ### bench/erf_mac_model.sv
// receive and transmit byte streams feeding the filter
// assumes one core_clk; drives on rising edges only
`timescale 1ns/10ps

module erf_mac_model (
    input  wire logic   core_clk,
    output logic        rx_valid,
    output logic        rx_sof,
    output logic        rx_eof,
    output erf_pkg::erf_byte_t rx_data,
    output logic        rx_crc_ok,
    output logic        tx_valid,
    output logic        tx_sof,
    output logic        tx_eof,
    output erf_pkg::erf_byte_t tx_data
);
    import erf_pkg::*;
    logic      v_ff = 1'b0;
    logic      s_ff = 1'b0;
    logic      e_ff = 1'b0;
    logic      t_ff = 1'b0;
    logic      ok_ff = 1'b1;
    erf_byte_t d_ff = 8'h00;
    assign rx_valid  = v_ff && !t_ff;
    assign tx_valid  = v_ff && t_ff;
    assign rx_sof    = s_ff;
    assign tx_sof    = s_ff;
    assign rx_eof    = e_ff;
    assign tx_eof    = e_ff;
    assign rx_data   = d_ff;
    assign tx_data   = d_ff;
    assign rx_crc_ok = ok_ff;
    // idle data shows the inverse of the last byte, never a held value
    task automatic send(input erf_byte_t q[$], input logic ok, input logic on_tx);
        for (int i = 0; i < q.size(); i++) begin
            @(posedge core_clk);
            v_ff <= 1'b1;
            t_ff <= on_tx;
            s_ff <= (i == 0);
            e_ff <= (i == q.size() - 1);
            d_ff <= q[i];
            ok_ff <= (i == q.size() - 1) ? ok : ~ok;
        end
        @(posedge core_clk);
        v_ff <= 1'b0;
        d_ff <= ~q[q.size() - 1];
        ok_ff <= ~ok;
    endtask : send
endmodule : erf_mac_model

// ### bench/erf_filter_tb.sv
// self-checking bench of the receive filter
// assumes the package, the mac model and the monitor are compiled first
`timescale 1ns/10ps
`include "erf_params.svh"

bind erf_filter erf_filter_monitor erf_filter_monitor_i (.*);

module erf_filter_tb;
    import erf_pkg::*;
    localparam logic [47:0] LOC = 48'h02A1B2C3D4E5;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        full_duplex_mode = 1'b0;
    logic        diagnostic_loopback_enable = 1'b0;
    logic        half_duplex_loopback_disable = 1'b1;
    logic [47:0] local_mac_address = LOC;
    logic [15:0] pattern_expected_checksum = 16'h0000;
    logic [12:0] pattern_window_offset = 13'h0000;
    logic [63:0] pattern_byte_mask = 64'h0;
    logic [63:0] hash_table_bits = 64'h0;
    logic [7:0]  receive_filter_control = 8'h00;
    logic        rx_valid, rx_sof, rx_eof, rx_crc_ok, tx_valid, tx_sof, tx_eof;
    erf_byte_t   rx_data, tx_data;
    logic        frame_keep, frame_drop;
    logic [5:0]  filter_hits;
    erf_byte_t   fr[$];
    int          err_total = 0;
    int          checks = 0;
    erf_mac_model erf_mac_model_i (.*);
    erf_filter erf_filter_i (.*);
    ////////////////////////////////////////////////////////////
    function automatic void mk(input logic [47:0] d, input int n);
        fr = {};
        for (int i = 0; i < n; i++)
            fr.push_back(i < 6 ? d[47 - 8 * i -: 8] : erf_byte_t'(8'h30 + i));
    endfunction : mk
    // masked bytes dropped before pairing
    function automatic logic [15:0] csum(input int o, input logic [63:0] m);
        erf_byte_t   b[$];
        logic [16:0] s;
        s = 17'h00000;
        for (int k = 0; k < 64; k++)
            if (m[k])
                b.push_back(fr[o + k]);
        if (b.size() % 2 == 1)
            b.push_back(8'h00);
        for (int k = 0; k < b.size(); k += 2)
            s = s[15:0] + {b[k], b[k + 1]} + s[16];
        s = s[15:0] + s[16];
        return ~s[15:0];
    endfunction : csum
    function automatic logic [5:0] hidx(input logic [47:0] a);
        logic [31:0] c;
        c = `ERF_CRC_INIT;
        for (int i = 0; i < 48; i++)
            c = (c >> 1) ^ ((c[0] ^ a[40 - 8 * (i / 8) + i % 8]) ? `ERF_CRC_POLY : 32'h0);
        return c[`ERF_HASH_LSB +: 6];
    endfunction : hidx
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : cmp
    task automatic cfg(input logic [7:0] c);
        @(posedge core_clk);
        receive_filter_control <= c;
    endtask : cfg
    task automatic run(input logic ok, input logic on_tx, input logic [1:0] kd);
        erf_mac_model_i.send(fr, ok, on_tx);
        @(posedge core_clk);
        #1;
        cmp({6'h00, frame_keep, frame_drop}, {6'h00, kd});
    endtask : run
    task automatic hit(input int k, input logic v);
        cmp({7'h00, filter_hits[k]}, {7'h00, v});
    endtask : hit
    ////////////////////////////////////////////////////////////
    task automatic t_unicast();
        cfg(8'h00);
        mk(48'h0A0B0C0D0E0F, 64);
        run(1'b0, 1'b0, 2'b10);
        cfg(8'h80);
        mk(LOC, 64);
        run(1'b1, 1'b0, 2'b10);
        hit(5, 1'b1);
        mk(LOC ^ 48'h1, 64);
        run(1'b1, 1'b0, 2'b01);
        cfg(8'hC1);
        mk(LOC, 64);
        run(1'b1, 1'b0, 2'b01);
        cfg(8'hC0);
        run(1'b1, 1'b0, 2'b10);
        cfg(8'h81);
        run(1'b1, 1'b0, 2'b10);
        cfg(8'h21);
        mk(48'hFFFFFFFFFFFF, 64);
        run(1'b1, 1'b0, 2'b10);
        run(1'b0, 1'b0, 2'b01);
    endtask : t_unicast
    task automatic t_group();
        logic [47:0] d [4] = '{48'hFFFFFFFFFFFF, 48'hFFFFFFFFFFFE, 48'h01005E000001, LOC};
        logic [1:0]  e [4] = '{2'b11, 2'b10, 2'b10, 2'b00};
        cfg(8'h03);
        for (int i = 0; i < 4; i++) begin
            mk(d[i], 64);
            run(1'b1, 1'b0, {|e[i], ~|e[i]});
            hit(1, e[i][1]);
            hit(0, e[i][0]);
        end
    endtask : t_group
    // mid-run reset must clear the standing hits of the last frame
    task automatic t_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        cmp({frame_keep, frame_drop, filter_hits}, 8'h00);
    endtask : t_reset
    task automatic t_hash();
        logic [63:0] t [4];
        t = '{64'h0, ~64'h0, 64'h1 << hidx(LOC), ~(64'h1 << hidx(LOC))};
        cfg(8'h04);
        mk(LOC, 64);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            hash_table_bits <= t[i];
            run(1'b1, 1'b0, {i == 1 || i == 2, i == 0 || i == 3});
            hit(2, i == 1 || i == 2);
        end
    endtask : t_hash
    task automatic t_pattern();
        cfg(8'h10);
        pattern_window_offset <= 13'h0004;
        pattern_byte_mask <= 64'h2FC;
        mk(LOC, 70);
        pattern_expected_checksum <= csum(4, 64'h2FC);
        run(1'b1, 1'b0, 2'b10);
        hit(4, 1'b1);
        @(posedge core_clk);
        pattern_expected_checksum <= csum(4, 64'h2FC) + 16'h0001;
        run(1'b1, 1'b0, 2'b01);
        @(posedge core_clk);
        pattern_byte_mask <= 64'h0;
        pattern_expected_checksum <= 16'hFFFF;
        mk(LOC, 68);
        run(1'b1, 1'b0, 2'b10);
        mk(LOC, 67);
        run(1'b1, 1'b0, 2'b01);
    endtask : t_pattern
    task automatic wake(input int n, input logic [1:0] kd);
        mk(LOC, 16);
        repeat (6)
            fr.push_back(8'hFF);
        for (int i = 0; i < 6 * n; i++)
            fr.push_back(LOC[47 - 8 * (i % 6) -: 8]);
        repeat (4)
            fr.push_back(8'h5A);
        run(1'b1, 1'b0, kd);
        hit(3, kd[1]);
    endtask : wake
    task automatic t_loop();
        cfg(8'h80);
        half_duplex_loopback_disable <= 1'b0;
        mk(LOC, 64);
        run(1'b0, 1'b1, 2'b10);
        @(posedge core_clk);
        half_duplex_loopback_disable <= 1'b1;
        run(1'b1, 1'b1, 2'b00);
        @(posedge core_clk);
        full_duplex_mode <= 1'b1;
        diagnostic_loopback_enable <= 1'b1;
        run(1'b1, 1'b0, 2'b00);
        run(1'b1, 1'b1, 2'b10);
        mk(LOC ^ 48'h1, 64);
        run(1'b1, 1'b1, 2'b01);
    endtask : t_loop
    task automatic complete_run();
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // 27 frames of up to 122 bytes; about four times that is a hang
    initial begin
        #40000;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        t_unicast();
        t_group();
        t_reset();
        t_hash();
        t_pattern();
        cfg(8'h08);
        wake(16, 2'b10);
        wake(15, 2'b01);
        t_loop();
        complete_run();
    end
endmodule : erf_filter_tb
